// >>> sdct_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - write with auto-precharge starts precharge one clock after last data; reuse after tRP plus one
// - full-page bursts ignore the auto-precharge request of reads and writes
// - a new read replaces the running read's data after its own latency
// - a new write takes data at once, replacing the running write burst
// - precharge: bit 10 high hits both banks, else bit 11 picks the bank
// - precharge ends a read; data already in flight still drains for latency clocks
// - same-bank precharge stops write storage at the precharge clock
// - full-page bursts walk 256 columns, wrap, and run until burst stop
// - burst stop on read: in-flight data drains for latency clocks, then float
// - burst stop on write: nothing stored from the stop clock on
// - read byte mask floats its lane two clocks later, releases two later
// - write byte mask blocks its lane's storage on the same clock
// - masks touch only data buffers; the burst counter keeps advancing
// - burst-read single-write mode stores one item per write command
// - clock enable low freezes all but the register bus from the next edge
// - column bits 8,9 ignored, bit 10 auto-precharge, bit 11 bank
module sdct_core
    import sdct_pkg::*;
#(
    parameter int ROW_W = 11
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cke_i,
    input wire sdct_pins_t cmd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [1:0] byte_lane_masks_i,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic [1:0] dq_oe_o
);
    localparam int MEM_AW = ROW_W + 1 + COL_W;

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic [31:0] cfg_reg, cfg_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic run_reg, run_next;
    sdct_bank_t bank_st_reg [2];
    sdct_bank_t bank_st_next [2];
    logic [ROW_W-1:0] bank_row_reg [2];
    logic [ROW_W-1:0] bank_row_next [2];
    logic [CNT_W-1:0] bank_cnt_reg [2];
    logic [CNT_W-1:0] bank_cnt_next [2];
    logic bst_act_reg, bst_act_next;
    logic bst_wr_reg, bst_wr_next;
    logic bst_bank_reg, bst_bank_next;
    logic bst_ap_reg, bst_ap_next;
    logic [COL_W-1:0] bst_start_reg, bst_start_next;
    logic [COL_W-1:0] bst_cnt_reg, bst_cnt_next;
    logic [COL_W-1:0] bst_len_reg, bst_len_next;
    sdct_beat_t pipe0_reg, pipe0_next;
    sdct_beat_t pipe1_reg, pipe1_next;
    logic [1:0] dqm_d_reg, dqm_d_next;
    logic [DQ_W-1:0] dq_reg, dq_next;
    logic [1:0] oe_reg, oe_next;
    logic [DQ_W-1:0] mem [0:(1 << MEM_AW)-1];

    // -------------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------------
    sdct_op_t op;
    logic cmd_on, cmd_bank, len_full;
    logic new_rd, new_wr, pre_hit, stop_hit;
    logic [COL_W-1:0] len_mask;
    assign op = sdct_op_t'({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n});
    // while suspended the whole command bus is ignored
    assign cmd_on = run_reg & ~cmd_i.cs_n;
    assign cmd_bank = addr_i[BANK_BIT];
    assign new_rd = cmd_on & (op == OP_RD) & (bank_st_reg[cmd_bank] == BANK_ACTIVE);
    assign new_wr = cmd_on & (op == OP_WR) & (bank_st_reg[cmd_bank] == BANK_ACTIVE);
    // a precharge of the other bank leaves the burst running
    assign pre_hit = cmd_on & (op == OP_PRE) & (addr_i[AP_BIT] | (cmd_bank == bst_bank_reg));
    assign stop_hit = cmd_on & (op == OP_BST);

    // burst length mask from the configured code; reserved codes act as one
    always_comb begin
        case (cfg_reg[CFG_BL_LSB +: 3])
            BL_CODE_2: len_mask = 8'h01;
            BL_CODE_4: len_mask = 8'h03;
            BL_CODE_8: len_mask = 8'h07;
            BL_CODE_FULL: len_mask = LEN_FULL;
            default: len_mask = 8'h00;
        endcase
    end
    assign len_full = (len_mask == LEN_FULL);

    // -------------------------------------------------------------------------
    // current beat of the burst engine
    // -------------------------------------------------------------------------
    logic beat, beat_wr, beat_bank, beat_ap, beat_last, ap_fire;
    logic [COL_W-1:0] beat_start, beat_cnt, beat_len, beat_col;
    logic [MEM_AW-1:0] beat_addr;
    logic [1:0] wr_lane;

    // a new column command wins over the running burst and replaces it
    always_comb begin
        beat = 1'b0;
        beat_wr = bst_wr_reg;
        beat_bank = bst_bank_reg;
        beat_ap = bst_ap_reg;
        beat_start = bst_start_reg;
        beat_cnt = bst_cnt_reg;
        beat_len = bst_len_reg;
        if (new_rd || new_wr) begin
            beat = 1'b1;
            beat_wr = new_wr;
            beat_bank = cmd_bank;
            beat_ap = addr_i[AP_BIT] & ~len_full;
            beat_start = addr_i[COL_W-1:0];
            beat_cnt = 8'h00;
            beat_len = (new_wr && cfg_reg[CFG_SWR_BIT]) ? 8'h00 : len_mask;
        end else if (bst_act_reg && !pre_hit && !stop_hit) begin
            beat = 1'b1;
        end
    end

    // sequential walks inside the aligned block, full page wraps at 256
    assign beat_col = cfg_reg[CFG_INTLV_BIT] ? (beat_start ^ beat_cnt)
        : ((beat_start & ~beat_len) | (8'(beat_start + beat_cnt) & beat_len));
    assign beat_last = (beat_cnt == beat_len) & (beat_len != LEN_FULL);
    assign ap_fire = run_reg & beat & beat_last & beat_ap;
    assign beat_addr = {beat_bank, bank_row_reg[beat_bank], beat_col};
    // masks gate storage per lane only; the counter still steps
    assign wr_lane = {2{run_reg & beat & beat_wr}} & ~byte_lane_masks_i;

    // -------------------------------------------------------------------------
    // burst engine and read pipeline
    // -------------------------------------------------------------------------
    always_comb begin
        bst_act_next = bst_act_reg;
        bst_wr_next = bst_wr_reg;
        bst_bank_next = bst_bank_reg;
        bst_ap_next = bst_ap_reg;
        bst_start_next = bst_start_reg;
        bst_cnt_next = bst_cnt_reg;
        bst_len_next = bst_len_reg;
        pipe0_next = pipe0_reg;
        pipe1_next = pipe1_reg;
        dqm_d_next = dqm_d_reg;
        dq_next = dq_reg;
        oe_next = oe_reg;
        // nothing moves while suspended, outputs included
        if (run_reg) begin
            bst_act_next = beat & ~beat_last;
            bst_wr_next = beat_wr;
            bst_bank_next = beat_bank;
            bst_ap_next = beat_ap;
            bst_start_next = beat_start;
            bst_cnt_next = 8'(beat_cnt + 8'h01);
            bst_len_next = beat_len;
            pipe0_next = '{valid: beat & ~beat_wr, data: mem[beat_addr]};
            pipe1_next = pipe0_reg;
            dqm_d_next = byte_lane_masks_i;
            // one pipe stage per latency step; mask path is fixed at two
            dq_next = cfg_reg[CFG_CL3_BIT] ? pipe1_reg.data : pipe0_reg.data;
            oe_next = {2{cfg_reg[CFG_CL3_BIT] ? pipe1_reg.valid : pipe0_reg.valid}} & ~dqm_d_reg;
        end
    end

    // -------------------------------------------------------------------------
    // bank state
    // -------------------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            bank_st_next[b] = bank_st_reg[b];
            bank_row_next[b] = bank_row_reg[b];
            bank_cnt_next[b] = bank_cnt_reg[b];
            if (run_reg) begin
                if (bank_st_reg[b] == BANK_PRECH) begin
                    if (bank_cnt_reg[b] == 8'h00) begin
                        bank_st_next[b] = BANK_IDLE;
                    end else begin
                        bank_cnt_next[b] = bank_cnt_reg[b] - 8'h01;
                    end
                end
                if (cmd_on && op == OP_ACT && cmd_bank == 1'(b) && (bank_st_reg[b] == BANK_IDLE
                        || (bank_st_reg[b] == BANK_PRECH && bank_cnt_reg[b] == 8'h00))) begin
                    bank_st_next[b] = BANK_ACTIVE;
                    bank_row_next[b] = addr_i[ROW_W-1:0];
                end
                if (cmd_on && op == OP_PRE && (addr_i[AP_BIT] || cmd_bank == 1'(b))
                        && bank_st_reg[b] == BANK_ACTIVE) begin
                    bank_st_next[b] = BANK_PRECH;
                    bank_cnt_next[b] = CNT_W'(TRP_CYC - 1);
                end
                // precharge begins one edge after the last beat, hence one more count
                if (ap_fire && beat_bank == 1'(b)) begin
                    bank_st_next[b] = BANK_PRECH;
                    bank_cnt_next[b] = CNT_W'(TRP_CYC);
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // register bus
    // -------------------------------------------------------------------------
    // one-cycle answer; ack drops the cycle after it rose
    always_comb begin
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        cfg_next = cfg_reg;
        dat_next = dat_reg;
        run_next = cke_i;
        if (ack_next && wb_we_i && wb_adr_i == CFG_OFFSET) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    cfg_next[8*i +: 8] = wb_dat_i[8*i +: 8];
                end
            end
        end
        if (ack_next && !wb_we_i) begin
            unique case (wb_adr_i)
                CFG_OFFSET: dat_next = cfg_reg;
                STAT_OFFSET: dat_next = {24'h000000, |oe_reg, ~run_reg, bst_wr_reg, bst_act_reg,
                    bank_st_reg[1], bank_st_reg[0]};
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= CFG_RESET;
            dat_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            run_reg <= 1'b0;
            for (int b = 0; b < 2; b++) begin
                bank_st_reg[b] <= BANK_IDLE;
                bank_row_reg[b] <= '0;
                bank_cnt_reg[b] <= 8'h00;
            end
            bst_act_reg <= 1'b0;
            bst_wr_reg <= 1'b0;
            bst_bank_reg <= 1'b0;
            bst_ap_reg <= 1'b0;
            bst_start_reg <= 8'h00;
            bst_cnt_reg <= 8'h00;
            bst_len_reg <= 8'h00;
            pipe0_reg <= '0;
            pipe1_reg <= '0;
            dqm_d_reg <= 2'h0;
            dq_reg <= 16'h0000;
            oe_reg <= 2'h0;
        end else begin
            cfg_reg <= cfg_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            run_reg <= run_next;
            bank_st_reg <= bank_st_next;
            bank_row_reg <= bank_row_next;
            bank_cnt_reg <= bank_cnt_next;
            bst_act_reg <= bst_act_next;
            bst_wr_reg <= bst_wr_next;
            bst_bank_reg <= bst_bank_next;
            bst_ap_reg <= bst_ap_next;
            bst_start_reg <= bst_start_next;
            bst_cnt_reg <= bst_cnt_next;
            bst_len_reg <= bst_len_next;
            pipe0_reg <= pipe0_next;
            pipe1_reg <= pipe1_next;
            dqm_d_reg <= dqm_d_next;
            dq_reg <= dq_next;
            oe_reg <= oe_next;
        end
    end

    // array has no reset; contents are undefined until written
    always_ff @(posedge clk_i) begin
        if (wr_lane[0]) begin
            mem[beat_addr][7:0] <= dq_i[7:0];
        end
        if (wr_lane[1]) begin
            mem[beat_addr][15:8] <= dq_i[15:8];
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign dq_o = dq_reg;
    assign dq_oe_o = oe_reg;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wr_ap_start_a: assert property (ap_fire && beat_wr && !beat_bank |=>
        bank_st_reg[0] == BANK_PRECH && bank_cnt_reg[0] == CNT_W'(TRP_CYC))
        else $error("write auto-precharge did not start precharge");
    full_no_ap_a: assert property (ap_fire |-> !len_full && beat_len != LEN_FULL)
        else $error("auto-precharge fired on a full-page burst");
    rd_restart_a: assert property (new_rd |=> pipe0_reg.valid && bst_cnt_reg == 8'h01
        && bst_start_reg == $past(addr_i[COL_W-1:0]))
        else $error("new read did not restart the burst");
    wr_restart_a: assert property (new_wr && byte_lane_masks_i == 2'h0 |-> wr_lane == 2'h3)
        else $error("new write did not store its first data");
    pre_all_a: assert property (cmd_on && op == OP_PRE && addr_i[AP_BIT]
        && bank_st_reg[0] == BANK_ACTIVE && bank_st_reg[1] == BANK_ACTIVE
        |=> bank_st_reg[0] == BANK_PRECH && bank_st_reg[1] == BANK_PRECH)
        else $error("precharge all missed a bank");
    pre_rd_stop_a: assert property (pre_hit && bst_act_reg && !new_rd |=> !bst_act_reg ##1 !pipe1_reg.valid)
        else $error("precharge did not end the read burst");
    pre_wr_block_a: assert property (pre_hit && bst_act_reg && bst_wr_reg && !new_wr
        |-> !beat && wr_lane == 2'h0)
        else $error("write stored on the precharge clock");
    page_wrap_a: assert property (run_reg && bst_act_reg && beat && !new_rd && !new_wr
        && bst_len_reg == LEN_FULL && bst_cnt_reg == 8'hFF |=> bst_act_reg && bst_cnt_reg == 8'h00)
        else $error("full-page burst did not wrap");
    stop_rd_a: assert property (stop_hit && bst_act_reg && !bst_wr_reg |=> !pipe0_reg.valid)
        else $error("burst stop did not end the read");
    stop_wr_a: assert property (stop_hit && !new_wr |-> wr_lane == 2'h0)
        else $error("write stored on the burst stop clock");
    rd_mask_a: assert property (dq_oe_o[0] && $past(run_reg) |-> !$past(byte_lane_masks_i[0], 2))
        else $error("low lane driven despite read mask");
    mask_count_a: assert property (run_reg && bst_act_reg && !new_rd && !new_wr && !pre_hit && !stop_hit
        |=> bst_cnt_reg == $past(bst_cnt_reg) + 8'h01)
        else $error("burst counter stalled");
    single_wr_a: assert property (new_wr && cfg_reg[CFG_SWR_BIT] |=> !bst_act_reg)
        else $error("single-write mode kept bursting");
    suspend_a: assert property (!run_reg |=> $stable(bst_cnt_reg) && $stable(dq_o) && $stable(bank_cnt_reg[0]))
        else $error("state moved during clock suspend");
endmodule : sdct_core
`default_nettype wire

// >>> sdct_pkg.sv
`default_nettype none
package sdct_pkg;
    // -------------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    // precharge time, plain default for a least time
    localparam int TRP_NS = 20;
    localparam int TRP_CYC_RAW = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRP_CYC = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
    localparam int CNT_W = 8;

    // -------------------------------------------------------------------------
    // register map and fields
    // -------------------------------------------------------------------------
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h4;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam int CFG_BL_LSB = 0;
    localparam int CFG_INTLV_BIT = 3;
    localparam int CFG_CL3_BIT = 4;
    localparam int CFG_SWR_BIT = 9;
    localparam logic [2:0] BL_CODE_1 = 3'h0;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_FULL = 3'h7;
    localparam logic [7:0] LEN_FULL = 8'hFF;

    // -------------------------------------------------------------------------
    // pin layout
    // -------------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int DQ_W = 16;
    localparam int AP_BIT = 10;
    localparam int BANK_BIT = 11;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdct_pins_t;

    typedef enum logic [2:0] {
        OP_MRS = 3'h0, OP_REF = 3'h1, OP_PRE = 3'h2, OP_ACT = 3'h3,
        OP_WR = 3'h4, OP_RD = 3'h5, OP_BST = 3'h6, OP_NOP = 3'h7
    } sdct_op_t;

    typedef enum logic [1:0] {
        BANK_IDLE = 2'b00,
        BANK_ACTIVE = 2'b01,
        BANK_PRECH = 2'b10
    } sdct_bank_t;

    typedef struct packed {
        logic valid;
        logic [DQ_W-1:0] data;
    } sdct_beat_t;
endpackage : sdct_pkg
`default_nettype wire

// >>> sdct_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// controller side: commands, masks and write data into the device
// -----------------------------------------------------------------------------
module sdct_ctrl_model
    import sdct_pkg::*;
(
    input wire logic clk_i,
    output logic cke_o,
    output sdct_pins_t cmd_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [1:0] mask_o,
    output logic [DQ_W-1:0] dq_o
);
    // banks this controller believes active
    logic [1:0] act_reg = 2'h0;
    // idle bus at time zero: clock enabled, nop, masks low
    initial begin
        cke_o = 1'b1;
        cmd_o = sdct_pins_t'(4'h7);
        addr_o = 12'h000;
        mask_o = 2'h0;
        dq_o = 16'h0000;
    end
    task set_cke(input logic v);
        cke_o <= v;
    endtask : set_cke
    // one command per edge; a column command to an idle bank is sent as nop
    task step(input logic [2:0] op, input logic [11:0] a, input logic [1:0] m, input logic [15:0] d,
        input logic w);
        logic bad;
        bad = (op == OP_RD || op == OP_WR) && !act_reg[a[BANK_BIT]];
        cmd_o <= sdct_pins_t'({1'b0, bad ? OP_NOP : op});
        addr_o <= a;
        mask_o <= m;
        dq_o <= w ? d : ~dq_o;
        if (op == OP_ACT) act_reg[a[BANK_BIT]] = 1'b1;
        if (op == OP_PRE) act_reg = a[AP_BIT] ? 2'h0 : act_reg & ~(2'h1 << a[BANK_BIT]);
        @(posedge clk_i);
    endtask : step
endmodule : sdct_ctrl_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sdct_pkg::*;
;
    logic clk_i, wb_ack_o, cke;
    logic rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'h4C;
    sdct_pins_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] msk, dq_oe_o, oe_s;
    logic [DQ_W-1:0] dq_i, dq_o, dq_s;
    logic [15:0] mem [256];
    int fail_count = 0, samples_checked = 0, i;
    sdct_core u_sdct_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cke_i(cke), .cmd_i(cmd), .addr_i(addr), .byte_lane_masks_i(msk), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o));
    sdct_ctrl_model u_sdct_ctrl_model (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .addr_o(addr),
        .mask_o(msk), .dq_o(dq_i));
    // -------------------------------------------------------------------------
    // clock, sampling and helpers
    // -------------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // mid-cycle copy, so checks never race the launching edge
    always @(negedge clk_i) begin
        dq_s <= dq_o;
        oe_s <= dq_oe_o;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_reg
    // floated lanes carry no data, so only driven lanes are compared
    task chk_beat(input logic [1:0] eo, input logic [15:0] ed);
        logic [15:0] m;
        m = {{8{eo[1]}}, {8{eo[0]}}};
        chk_reg(32'({oe_s, dq_s & m}), 32'({eo, ed & m}));
    endtask : chk_beat
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        // no local limit: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task s(input logic [2:0] op, input logic [11:0] a, input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0,
        input logic w = 1'b0);
        u_sdct_ctrl_model.step(op, a, m, d, w);
    endtask : s
    // n random beats from column a; the first st land in memory, beat 1 carries mask m
    task wr(input logic [11:0] a, input int n, input int st, input logic [1:0] m);
        logic [15:0] d;
        logic [7:0] c;
        logic [1:0] mk;
        for (int k = 0; k < n; k++) begin
            d = 16'(rnd());
            mk = (k == 1) ? m : 2'h0;
            c = 8'(a[7:0] + k);
            s(k == 0 ? OP_WR : OP_NOP, a, mk, d, 1'b1);
            if (k < st) mem[c] = {mk[1] ? mem[c][15:8] : d[15:8], mk[0] ? mem[c][7:0] : d[7:0]};
        end
    endtask : wr
    task rdchk(input logic [7:0] a, input int n, input int cl);
        s(OP_RD, {4'h0, a});
        for (int j = 1; j <= n + cl; j++) begin
            s(OP_NOP, 12'h000);
            if (j >= cl) chk_beat(j < n + cl ? 2'h3 : 2'h0, mem[8'(a + j - cl)]);
        end
    endtask : rdchk
    task wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // -------------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------------
    initial begin
        #(20 * 3000);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wb(1'b0, CFG_OFFSET, 32'h0);
        chk_reg(q, CFG_RESET);
        wb(1'b1, CFG_OFFSET, 32'h2);
        wb(1'b0, CFG_OFFSET, 32'h0);
        chk_reg(q, 32'h2);
        wb(1'b0, 4'h8, 32'h0);
        chk_reg(q, 32'h0);
        s(OP_ACT, 12'h005);
        s(OP_NOP, 12'h000);
        wb(1'b0, STAT_OFFSET, 32'h0);
        chk_reg(q & 32'hF, 32'h1);
        $display("test registers done");
        // masked rewrite keeps the old high byte, burst still advances
        wr(12'h000, 4, 4, 2'h0);
        wr(12'h004, 4, 4, 2'h0);
        wr(12'h000, 4, 4, 2'h2);
        rdchk(8'h00, 4, 2);
        $display("test write mask done");
        // second read replaces the first; high lane masked at edge 1
        s(OP_RD, 12'h000);
        s(OP_NOP, 12'h000, 2'h2);
        s(OP_RD, 12'h004);
        chk_beat(2'h3, mem[0]);
        s(OP_NOP, 12'h000);
        chk_beat(2'h1, mem[1]);
        for (i = 0; i < 5; i++) begin
            s(OP_NOP, 12'h000);
            chk_beat(i < 4 ? 2'h3 : 2'h0, mem[4 + i]);
        end
        $display("test read interrupt done");
        // latency 3 read cut by precharge, then both banks activated
        wb(1'b1, CFG_OFFSET, 32'h12);
        s(OP_RD, 12'h000);
        s(OP_PRE, 12'h000);
        s(OP_NOP, 12'h000);
        s(OP_NOP, 12'h000);
        chk_beat(2'h3, mem[0]);
        s(OP_NOP, 12'h000);
        chk_beat(2'h0, 16'h0);
        s(OP_ACT, 12'h805);
        s(OP_NOP, 12'h000);
        s(OP_ACT, 12'h005);
        s(OP_NOP, 12'h000);
        // write cut by a same-bank precharge with masks up: column 7 keeps its old word
        wr(12'h004, 3, 3, 2'h0);
        s(OP_PRE, 12'h000, 2'h3, 16'h5A5A, 1'b1);
        repeat (TRP_CYC) s(OP_NOP, 12'h000);
        s(OP_ACT, 12'h005);
        s(OP_NOP, 12'h000);
        // whole burst kept when the precharge follows the last data by one clock
        wr(12'h008, 4, 4, 2'h0);
        s(OP_PRE, 12'hC00);
        repeat (TRP_CYC + 1) s(OP_NOP, 12'h000);
        wb(1'b0, STAT_OFFSET, 32'h0);
        chk_reg(q & 32'hF, 32'h0);
        $display("test precharge done");
        // full page: wrap past column 255, burst stop on write and read
        wb(1'b1, CFG_OFFSET, 32'h7);
        s(OP_ACT, 12'h005);
        s(OP_NOP, 12'h000);
        wr(12'h4FE, 4, 4, 2'h0);
        s(OP_BST, 12'h000, 2'h0, 16'h5A5A, 1'b1);
        wb(1'b0, STAT_OFFSET, 32'h0);
        chk_reg(q & 32'h3, 32'h1);
        s(OP_RD, 12'h0FE);
        for (i = 1; i < 8; i++) begin
            s(i == 5 ? OP_BST : OP_NOP, 12'h000);
            if (i >= 2) chk_beat(i < 7 ? 2'h3 : 2'h0, mem[8'(8'hFE + i - 2)]);
        end
        // a long read goes past count 255 and comes back to its start column
        s(OP_RD, 12'h0FE);
        for (i = 1; i < 262; i++) begin
            s(i == 259 ? OP_BST : OP_NOP, 12'h000);
            if (i == 2 || i == 258 || i == 261) chk_beat(i < 261 ? 2'h3 : 2'h0, mem[8'hFE]);
        end
        $display("test full page done");
        wb(1'b1, CFG_OFFSET, 32'h202);
        wr(12'h000, 4, 1, 2'h0);
        rdchk(8'h00, 4, 2);
        $display("test single write done");
        // eight-beat interleaved read from column 1 runs 1, 0, 3, 2, 5, 4, 7, 6
        wb(1'b1, CFG_OFFSET, 32'hB);
        s(OP_RD, 12'h001);
        for (i = 1; i <= 10; i++) begin
            s(OP_NOP, 12'h000);
            if (i >= 2) chk_beat(i < 10 ? 2'h3 : 2'h0, mem[8'(i - 2) ^ 8'h01]);
        end
        $display("test interleave done");
        // auto-precharge write, column bits 8 and 9 set but ignored
        wb(1'b1, CFG_OFFSET, 32'h2);
        wr(12'h700, 4, 4, 2'h0);
        repeat (TRP_CYC) s(OP_NOP, 12'h000);
        s(OP_ACT, 12'h005);
        s(OP_NOP, 12'h000);
        rdchk(8'h00, 4, 2);
        rdchk(8'h04, 4, 2);
        rdchk(8'h08, 4, 2);
        $display("test auto precharge done");
        // suspend: a read while clock enable is low must be ignored
        u_sdct_ctrl_model.set_cke(1'b0);
        s(OP_NOP, 12'h000);
        s(OP_RD, 12'h000);
        for (i = 0; i < 4; i++) begin
            s(OP_NOP, 12'h000);
            chk_beat(2'h0, 16'h0);
        end
        wb(1'b0, STAT_OFFSET, 32'h0);
        chk_reg(q & 32'h40, 32'h40);
        u_sdct_ctrl_model.set_cke(1'b1);
        repeat (2) s(OP_NOP, 12'h000);
        rdchk(8'h00, 4, 2);
        $display("test suspend done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
